/* File: core/bpsc_consts.svh */
// Purpose: constants for the debug status/control register bank
// Assumes: 64-bit registers, bit positions as laid out below
// Notes: fixed-bit masks apply to the low word only
`ifndef BPSC_CONSTS_SVH
`define BPSC_CONSTS_SVH
`define BPSC_NUM_BP 4
`define BPSC_STAT_TASK_BIT 15
`define BPSC_STAT_STEP_BIT 14
`define BPSC_STAT_ACC_BIT 13
`define BPSC_STAT_ONES_MASK 64'h0000_0000_FFFF_0FF0
`define BPSC_STAT_RW_MASK 64'h0000_0000_0000_E00F
`define BPSC_STAT_RESET 64'h0000_0000_FFFF_0FF0
`define BPSC_CTRL_GD_BIT 13
`define BPSC_CTRL_ONES_MASK 64'h0000_0000_0000_0400
`define BPSC_CTRL_RW_MASK 64'h0000_0000_FFFF_23FF
`define BPSC_CTRL_RESET 64'h0000_0000_0000_0400
`define BPSC_CTRL_LOCAL_MASK 64'h0000_0000_0000_0055
`define BPSC_CTRL_TYPE_LSB 16
`define BPSC_CTRL_LEN_LSB 18
`define BPSC_TYPE_EXEC 2'h0
`define BPSC_TYPE_WRITE 2'h1
`define BPSC_TYPE_IO 2'h2
`define BPSC_TYPE_RDWR 2'h3
`define BPSC_LEN_1 2'h0
`define BPSC_LEN_2 2'h1
`define BPSC_LEN_8 2'h2
`define BPSC_LEN_4 2'h3
`endif

/* File: core/bpsc_match.sv */
// Purpose: one address breakpoint comparator
// Assumes: address held aligned to its length by software
// Notes: undefined encodings simply never match
`timescale 1ns/1ps
`include "bpsc_consts.svh"
module bpsc_match
	import bpsc_pkg::*;
(
	// Setup
	input wire bpsc_slot_s slot,
	input wire logic [63:0] bp_addr,
	input wire logic long_mode,
	input wire logic debug_ext_enable,
	// Reference
	input wire bpsc_ref_s ref_in,
	// Result
	output logic hit
);
	logic [63:0] mask;
	logic type_ok;
	always_comb
	begin
		case (slot.len)
			`BPSC_LEN_1: mask = 64'hFFFF_FFFF_FFFF_FFFF;
			`BPSC_LEN_2: mask = 64'hFFFF_FFFF_FFFF_FFFE;
			`BPSC_LEN_4: mask = 64'hFFFF_FFFF_FFFF_FFFC;
			`BPSC_LEN_8: mask = long_mode ? 64'hFFFF_FFFF_FFFF_FFF8 : 64'h0;
			default: mask = 64'hFFFF_FFFF_FFFF_FFFF;
		endcase
		case (slot.kind)
			`BPSC_TYPE_EXEC: type_ok = ref_in.kind == BPSC_ACC_EXEC;
			`BPSC_TYPE_WRITE: type_ok = ref_in.kind == BPSC_ACC_WRITE;
			`BPSC_TYPE_IO: type_ok = debug_ext_enable && ref_in.kind == BPSC_ACC_IO;
			`BPSC_TYPE_RDWR: type_ok = ref_in.kind == BPSC_ACC_WRITE
				|| ref_in.kind == BPSC_ACC_READ;
			default: type_ok = 1'b0;
		endcase
		// Undefined 8-byte length outside long mode blocks the match
		hit = ref_in.valid && type_ok && (mask != 64'h0)
			&& ((ref_in.addr & mask) == (bp_addr & mask));
	end
endmodule

/* File: core/bpsc_pkg.sv */
// Purpose: types for the debug status/control register bank
// Assumes: one reference from the pipeline per cycle
// Notes: none
package bpsc_pkg;
	typedef enum logic [1:0] {
		BPSC_ACC_EXEC = 2'b00,
		BPSC_ACC_WRITE = 2'b01,
		BPSC_ACC_IO = 2'b10,
		BPSC_ACC_READ = 2'b11
	} bpsc_acc_e;
	typedef struct packed {
		logic valid;
		bpsc_acc_e kind;
		logic [63:0] addr;
	} bpsc_ref_s;
	typedef struct packed {
		logic [1:0] len;
		logic [1:0] kind;
		logic glob;
		logic loc;
	} bpsc_slot_s;
endpackage

/* File: core/bpsc_regs.sv */
// Purpose: debug status and control registers with event capture
// Assumes: pipeline gives one reference, step/task/access events per cycle
// Notes: access is through the documented register-move port
`timescale 1ns/1ps
`include "bpsc_consts.svh"
module bpsc_regs
	import bpsc_pkg::*;
#(
	parameter int NUM_BP = `BPSC_NUM_BP
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Mode
	input wire logic long_mode,
	input wire logic debug_ext_enable,
	// Register move port: sel 0..3 address regs, 6 status, 7 control
	input wire logic reg_access,
	input wire logic reg_write,
	input wire logic [2:0] reg_sel,
	input wire logic [63:0] reg_wdata,
	output logic [63:0] reg_rdata,
	output logic gp_fault,
	// Pipeline events
	input wire bpsc_ref_s ref_in,
	input wire logic single_step_trap_flag,
	input wire logic task_switch,
	input wire logic task_trap,
	// Exception
	output logic debug_exception,
	output logic [NUM_BP-1:0] match_hits
);
	logic [63:0] status_reg, status_next;
	logic [63:0] control_reg, control_next;
	logic [63:0] bp_addr_reg [NUM_BP];
	logic [63:0] bp_addr_next [NUM_BP];
	logic [63:0] rdata_reg, rdata_next;
	logic fault_reg, fault_next;
	logic [NUM_BP-1:0] raw_hit, en_hit;
	logic acc_guard, step_ev, task_ev, bp_ev, event_any, upper_bad;
	logic move_ok, wr_fixed, fault_cond;
	logic [63:0] read_word;

	genvar g;
	generate
		for (g = 0; g < NUM_BP; g++)
		begin : g_bp
			bpsc_slot_s slot;
			always_comb
			begin
				slot.loc = control_reg[2*g];
				slot.glob = control_reg[2*g+1];
				slot.kind = control_reg[`BPSC_CTRL_TYPE_LSB+4*g +: 2];
				slot.len = control_reg[`BPSC_CTRL_LEN_LSB+4*g +: 2];
			end
			bpsc_match u_match
			(
				.slot(slot),
				.bp_addr(bp_addr_reg[g]),
				.long_mode(long_mode),
				.debug_ext_enable(debug_ext_enable),
				.ref_in(ref_in),
				.hit(raw_hit[g])
			);
			assign en_hit[g] = raw_hit[g] && (slot.loc || slot.glob);
		end
	endgenerate

	always_comb
	begin
		acc_guard = reg_access && control_reg[`BPSC_CTRL_GD_BIT];
		step_ev = single_step_trap_flag;
		task_ev = task_switch && task_trap;
		bp_ev = |en_hit;
		event_any = acc_guard || step_ev || task_ev || bp_ev;
		upper_bad = long_mode && (reg_wdata[63:32] != 32'h0);
	end
	assign debug_exception = event_any;
	assign match_hits = en_hit;
	assign reg_rdata = rdata_reg;
	assign gp_fault = fault_reg;

	// Move decode kept apart so the trap path stays readable
	always_comb
	begin
		move_ok = reg_access && !acc_guard;
		wr_fixed = reg_write && (reg_sel == 3'h6 || reg_sel == 3'h7);
		fault_cond = move_ok && wr_fixed && upper_bad;
	end

	// Read mux; 4 and 5 return zero rather than aliasing
	always_comb
	begin
		case (reg_sel)
			3'h6: read_word = status_reg;
			3'h7: read_word = control_reg;
			3'h4, 3'h5: read_word = 64'h0;
			default: read_word = bp_addr_reg[reg_sel[1:0]];
		endcase
		// Legacy modes only see the low word
		if (!long_mode)
			read_word[63:32] = 32'h0;
	end

	always_comb
	begin
		status_next = status_reg;
		control_next = control_reg;
		fault_next = 1'b0;
		rdata_next = rdata_reg;
		for (int i = 0; i < NUM_BP; i++)
			bp_addr_next[i] = bp_addr_reg[i];
		// Guarded access traps before the move executes
		if (move_ok)
		begin
			if (fault_cond)
				fault_next = 1'b1;
			else if (reg_write)
			begin
				case (reg_sel)
					3'h6: status_next = (reg_wdata & `BPSC_STAT_RW_MASK)
						| `BPSC_STAT_ONES_MASK;
					3'h7: control_next = (reg_wdata & `BPSC_CTRL_RW_MASK)
						| `BPSC_CTRL_ONES_MASK;
					3'h4, 3'h5: ;
					default: bp_addr_next[reg_sel[1:0]] = long_mode ? reg_wdata
						: {32'h0, reg_wdata[31:0]};
				endcase
			end
			else
				rdata_next = read_word;
		end
		// Status capture wins over a same-cycle software write
		if (event_any)
		begin
			status_next[NUM_BP-1:0] = en_hit;
			// Sticky bits set here or by a software status write; software clears them
			if (acc_guard)
				status_next[`BPSC_STAT_ACC_BIT] = 1'b1;
			if (step_ev)
				status_next[`BPSC_STAT_STEP_BIT] = 1'b1;
			if (task_ev)
				status_next[`BPSC_STAT_TASK_BIT] = 1'b1;
			control_next[`BPSC_CTRL_GD_BIT] = 1'b0;
		end
		if (task_switch)
			control_next = control_next & ~`BPSC_CTRL_LOCAL_MASK;
		status_next = (status_next & `BPSC_STAT_RW_MASK) | `BPSC_STAT_ONES_MASK;
	end

	// Status register
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			status_reg <= `BPSC_STAT_RESET;
		else
			status_reg <= status_next;
	end

	// Control register
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			control_reg <= `BPSC_CTRL_RESET;
		else
			control_reg <= control_next;
	end

	// Move answer: read data holds until the next read
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rdata_reg <= 64'h0;
			fault_reg <= 1'b0;
		end
		else
		begin
			rdata_reg <= rdata_next;
			fault_reg <= fault_next;
		end
	end

	// Address breakpoint registers
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			for (int i = 0; i < NUM_BP; i++)
				bp_addr_reg[i] <= 64'h0;
		end
		else
		begin
			for (int i = 0; i < NUM_BP; i++)
				bp_addr_reg[i] <= bp_addr_next[i];
		end
	end
endmodule

/* File: test/bpsc_pipe_model.sv */
// Purpose: pipeline side raising references and events
// Assumes: one-cycle events from the falling edge
// Notes: released address is inverted so it never lingers
`timescale 1ns/1ps
module bpsc_pipe_model
	import bpsc_pkg::*;
(
	// Events
	input wire logic clk,
	input wire logic debug_exception,
	output bpsc_ref_s ref_in,
	output logic single_step_trap_flag,
	output logic task_switch,
	output logic task_trap,
	output logic exc_seen
);
	initial
	begin
		{ref_in, single_step_trap_flag, task_switch, task_trap, exc_seen} = '0;
	end
	task automatic fire(input logic v, input bpsc_acc_e k, input logic [63:0] a,
		input logic [2:0] ev);
		@(negedge clk);
		ref_in = {v, k, a};
		{single_step_trap_flag, task_switch, task_trap} = ev;
		#1 exc_seen = debug_exception;
		@(negedge clk);
		ref_in = {1'b0, k, ~a};
		{single_step_trap_flag, task_switch, task_trap} = 3'h0;
	endtask
endmodule

/* File: test/bpsc_regs_monitor.sv */
// Purpose: port checks of the register bank
// Assumes: one clock, nrst async low
// Notes: guarded moves are left out of fault checks
`timescale 1ns/1ps
module bpsc_regs_monitor
	import bpsc_pkg::*;
#(
	parameter int NUM_BP = 4
)
(
	// Watched
	input wire logic clk,
	input wire logic nrst,
	input wire logic long_mode,
	input wire logic reg_access,
	input wire logic reg_write,
	input wire logic [2:0] reg_sel,
	input wire logic [63:0] reg_wdata,
	input wire logic [63:0] reg_rdata,
	input wire logic gp_fault,
	input wire bpsc_ref_s ref_in,
	input wire logic single_step_trap_flag,
	input wire logic task_switch,
	input wire logic task_trap,
	input wire logic debug_exception,
	input wire logic [NUM_BP-1:0] match_hits
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	wire logic up_wr = reg_access && reg_write && long_mode && reg_sel[2:1] == 2'h3;
	wire logic up_one = up_wr && |reg_wdata[63:32];
	chk_fault_raise: assert property (up_one && !debug_exception |=> gp_fault)
		else $error("no fault on upper write");
	chk_fault_cause: assert property (gp_fault |-> $past(up_one))
		else $error("fault without cause");
	chk_status_fixed: assert property (reg_access && !reg_write && reg_sel == 3'h6
		&& !debug_exception |=> (reg_rdata & 64'hFFFF_FFFF_FFFF_1FF0) == 64'hFFFF_0FF0)
		else $error("status reserved bits wrong");
	chk_hit_raise: assert property (|match_hits |-> debug_exception)
		else $error("hit without exception");
	chk_hit_valid: assert property (!ref_in.valid |-> match_hits == '0)
		else $error("hit without reference");
	chk_step_raise: assert property (single_step_trap_flag |-> debug_exception)
		else $error("step without exception");
	chk_task_raise: assert property (task_switch && task_trap |-> debug_exception)
		else $error("task trap without exception");
	chk_guard_clear: assert property (debug_exception ##1 (reg_access && !ref_in.valid
		&& !single_step_trap_flag && !task_switch) |-> !debug_exception)
		else $error("guard still set");
	cover property (gp_fault);
	cover property (reg_access && debug_exception);
	cover property (|match_hits);
endmodule

/* File: test/bpsc_regs_tb_top.sv */
// Purpose: directed checks of the register bank
// Assumes: inputs change on the falling edge
// Notes: I/O-type matching exercised with debug_ext_enable set and clear
`timescale 1ns/1ps
module bpsc_regs_tb_top import bpsc_pkg::*;;
	logic clk, nrst, long_mode, debug_ext_enable, reg_access, reg_write, gp_fault;
	logic single_step_trap_flag, task_switch, task_trap, debug_exception, exc_seen, acc_exc;
	logic [2:0] reg_sel;
	logic [63:0] reg_wdata, reg_rdata;
	logic [3:0] match_hits;
	bpsc_ref_s ref_in;
	int miscompares = 0;
	int checks_done = 0;
	bpsc_regs dut(.*);
	bpsc_pipe_model pm(.*);
	initial
	begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic mv(input logic w, input logic [2:0] s, input logic [63:0] d);
		@(negedge clk);
		{reg_access, reg_write, reg_sel, reg_wdata} = {1'b1, w, s, d};
		#1 acc_exc = debug_exception;
		@(negedge clk);
		{reg_access, reg_wdata} = {1'b0, ~d};
	endtask
	task automatic rd(input logic [2:0] s, input logic [63:0] e);
		mv(0, s, 64'h0);
		check(reg_rdata, e);
	endtask
	task automatic t_fixed();
		rd(3'h6, 64'hFFFF_0FF0);
		rd(3'h7, 64'h0400);
		mv(1, 3'h6, '1);
		rd(3'h6, 64'hFFFF_EFFF);
		mv(1, 3'h6, 64'h0);
		rd(3'h6, 64'hFFFF_0FF0);
	endtask
	task automatic t_fault();
		long_mode = 1;
		mv(1, 3'h6, 64'h8000_0000_0000_E00F);
		check(gp_fault, 1);
		rd(3'h6, 64'hFFFF_0FF0);
		long_mode = 0;
	endtask
	task automatic t_match();
		mv(1, 3'h0, 64'h100);
		mv(1, 3'h7, 64'h000D_0001);
		pm.fire(1, BPSC_ACC_EXEC, 64'h100, 3'h0);
		check(exc_seen, 0);
		pm.fire(1, BPSC_ACC_WRITE, 64'h104, 3'h0);
		check(exc_seen, 0);
		pm.fire(1, BPSC_ACC_WRITE, 64'h103, 3'h0);
		check(exc_seen, 1);
		rd(3'h6, 64'hFFFF_0FF1);
		pm.fire(1, BPSC_ACC_WRITE, 64'h100, 3'h4);
		rd(3'h6, 64'hFFFF_4FF1);
		pm.fire(0, BPSC_ACC_EXEC, 64'h0, 3'h4);
		check(exc_seen, 1);
		rd(3'h6, 64'hFFFF_4FF0);
	endtask
	task automatic t_task();
		mv(1, 3'h7, 64'h9);
		pm.fire(0, BPSC_ACC_EXEC, 64'h0, 3'h3);
		check(exc_seen, 1);
		rd(3'h6, 64'hFFFF_CFF0);
		rd(3'h7, 64'h0408);
	endtask
	task automatic t_guard();
		mv(1, 3'h7, 64'h2000);
		mv(0, 3'h6, 64'h0);
		check(acc_exc, 1);
		rd(3'h7, 64'h0400);
		rd(3'h6, 64'hFFFF_EFF0);
	endtask
	task automatic t_io();
		debug_ext_enable = 1;
		mv(1, 3'h7, 64'h0002_0002);
		pm.fire(1, BPSC_ACC_IO, 64'h100, 3'h0);
		check(exc_seen, 1);
		rd(3'h6, 64'hFFFF_EFF1);
		debug_ext_enable = 0;
		pm.fire(1, BPSC_ACC_IO, 64'h100, 3'h0);
		check(exc_seen, 0);
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		{nrst, long_mode, debug_ext_enable, reg_access, reg_write, reg_sel, reg_wdata} = '0;
		repeat (8) @(negedge clk);
		nrst = 1;
		t_fixed();
		t_fault();
		t_match();
		t_task();
		t_guard();
		t_io();
		wrap_up();
	end
	initial
	begin
		#20000;
		miscompares++;
		wrap_up();
	end
endmodule
bind bpsc_regs bpsc_regs_monitor #(.NUM_BP(NUM_BP)) mon(.clk(clk), .nrst(nrst),
	.long_mode(long_mode), .reg_access(reg_access), .reg_write(reg_write),
	.reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .gp_fault(gp_fault),
	.ref_in(ref_in), .single_step_trap_flag(single_step_trap_flag),
	.task_switch(task_switch), .task_trap(task_trap),
	.debug_exception(debug_exception), .match_hits(match_hits));
